// *** verif/reset_pin_model.sv ***
// partner: external reset pin source with board pull-up
`timescale 1ns/100ps
module reset_pin_model (
    // press request from the bench
    input wire logic press,
    // pin, idles high through the pull-up
    output logic rst_pin_n
);
    assign rst_pin_n = press ? 1'b0 : 1'b1;
endmodule : reset_pin_model

// *** verif/three_level_reset_generator_monitor.sv ***
// checker: reset nesting and source relations
`timescale 1ns/100ps
module three_level_reset_generator_monitor
    import reset_gen_pkg::*;
(
    // watched ports
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire full_src_t FULL_SRC,
    input wire logic SW_MID_WR,
    input wire logic SW_MID_DATA,
    input wire soft_src_t SOFT_SRC,
    input wire reset_levels_t RESETS,
    input wire logic SW_MID_PULSE,
    input wire logic SW_MID_RDATA,
    input wire logic PIN_MODE,
    input wire wdog_mode_t WDOG_MODE,
    input wire logic WDOG_RUN
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);
    a_full_nests_mid: assert property (RESETS.full_device_reset |-> RESETS.middle_reset)
        else $error("full reset without middle reset");
    a_mid_nests_soft: assert property (RESETS.middle_reset |-> RESETS.soft_clear_reset)
        else $error("middle reset without soft-clear reset");
    a_sw_full_req: assert property (FULL_SRC.sw_full_req |=> RESETS.full_device_reset)
        else $error("software full request missed");
    a_sw_mid_req: assert property (SW_MID_WR && SW_MID_DATA |=> RESETS.middle_reset)
        else $error("software middle request missed");
    a_mid_no_escalate: assert property ($rose(RESETS.middle_reset) |-> $past(SW_MID_PULSE) || RESETS.full_device_reset)
        else $error("middle reset from a foreign source");
    a_pulse_bit: assert property (SW_MID_PULSE == (SW_MID_WR && SW_MID_DATA) && !SW_MID_RDATA)
        else $error("pulse bit misbehaves");
    a_soft_sources: assert property (|SOFT_SRC[3:0] |=> RESETS.soft_clear_reset)
        else $error("soft-clear source missed");
    a_wdog_expiry: assert property (SOFT_SRC.wdog_expired && WDOG_MODE == WDOG_MODE_WATCHDOG |=> RESETS.soft_clear_reset)
        else $error("watchdog expiry missed");
    a_full_config: assert property (RESETS.full_device_reset |=> !PIN_MODE && WDOG_MODE == WDOG_MODE_WATCHDOG && WDOG_RUN)
        else $error("configuration not restored");
endmodule : three_level_reset_generator_monitor
bind three_level_reset_generator three_level_reset_generator_monitor i_three_level_reset_generator_monitor (
    .CLK_SYS, .RESETN, .FULL_SRC, .SW_MID_WR, .SW_MID_DATA, .SOFT_SRC, .RESETS,
    .SW_MID_PULSE, .SW_MID_RDATA, .PIN_MODE, .WDOG_MODE, .WDOG_RUN);

// *** verif/three_level_reset_generator_tb_top.sv ***
// testbench: directed scenarios for the reset generator
`timescale 1ns/100ps
module three_level_reset_generator_tb_top;
    import reset_gen_pkg::*;
    logic clk_sys, resetn, press, rst_pin_n, sw_mid_wr, sw_mid_data, pm_wr, pm_d, wm_wr, wr_wr, wr_d;
    logic sw_mid_pulse, sw_mid_rdata, pin_mode, wdog_run;
    wdog_mode_t wm_d, wdog_mode;
    full_src_t full_src;
    soft_src_t soft_src;
    reset_levels_t resets;
    int miscompares, cmp_count;
    reset_pin_model i_reset_pin_model (.press(press), .rst_pin_n(rst_pin_n));
    three_level_reset_generator i_three_level_reset_generator (.CLK_SYS(clk_sys), .RESETN(resetn),
        .RST_PIN_N(rst_pin_n), .FULL_SRC(full_src), .SW_MID_WR(sw_mid_wr), .SW_MID_DATA(sw_mid_data),
        .SOFT_SRC(soft_src), .PIN_MODE_WR(pm_wr), .PIN_MODE_DATA(pm_d), .WDOG_MODE_WR(wm_wr),
        .WDOG_MODE_DATA(wm_d), .WDOG_RUN_WR(wr_wr), .WDOG_RUN_DATA(wr_d), .RESETS(resets),
        .SW_MID_PULSE(sw_mid_pulse), .SW_MID_RDATA(sw_mid_rdata), .PIN_MODE(pin_mode),
        .WDOG_MODE(wdog_mode), .WDOG_RUN(wdog_run));
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic hit(input full_src_t f, input soft_src_t s, input logic [2:0] exp);
        full_src = f;
        soft_src = s;
        @(negedge clk_sys);
        chk(resets, exp);
        full_src = '0;
        soft_src = '0;
        @(negedge clk_sys);
    endtask : hit
    task automatic wr_cfg(input logic pm, input wdog_mode_t wm, input logic run);
        {pm_wr, wm_wr, wr_wr, pm_d, wr_d} = {3'h7, pm, run};
        wm_d = wm;
        @(negedge clk_sys);
        {pm_wr, wm_wr, wr_wr} = 3'h0;
        @(negedge clk_sys);
    endtask : wr_cfg
    task automatic wait_lvl(input logic [2:0] exp);
        int n;
        n = 0;
        while (resets !== exp && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        if (resets !== exp) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_lvl
    task automatic t_soft;
        for (int i = 0; i < 4; i++) hit('0, soft_src_t'(5'h01 << i), 3'h1);
    endtask : t_soft
    task automatic t_wdog;
        hit('0, 5'h10, 3'h1);
        wr_cfg(1'b0, WDOG_MODE_INTERVAL, 1'b1);
        hit('0, 5'h10, 3'h0);
        wr_cfg(1'b0, WDOG_MODE_WATCHDOG, 1'b1);
    endtask : t_wdog
    task automatic t_mid;
        {sw_mid_wr, sw_mid_data} = 2'h3;
        #1 chk({1'b0, sw_mid_pulse, sw_mid_rdata}, 3'h2);
        @(negedge clk_sys);
        chk(resets, 3'h3);
        sw_mid_data = 1'b0;
        #1 chk({1'b0, sw_mid_pulse, sw_mid_rdata}, 3'h0);
        @(negedge clk_sys);
        chk(resets, 3'h0);
        sw_mid_wr = 1'b0;
    endtask : t_mid
    task automatic t_full;
        full_src_t fs [4] = '{5'h10, 5'h08, 5'h06, 5'h01};
        for (int i = 0; i < 4; i++) begin
            wr_cfg(PIN_MODE_NMI, WDOG_MODE_INTERVAL, 1'b0);
            chk({pin_mode, wdog_mode, wdog_run}, 3'h6);
            hit(fs[i], '0, 3'h7);
            chk({pin_mode, wdog_mode, wdog_run}, 3'h1);
        end
        hit(5'h04, '0, 3'h0);
    endtask : t_full
    task automatic t_pin;
        press = 1'b1;
        wait_lvl(3'h7);
        chk(resets, 3'h7);
        press = 1'b0;
        wait_lvl(3'h0);
        wr_cfg(PIN_MODE_NMI, WDOG_MODE_WATCHDOG, 1'b1);
        press = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(resets, 3'h0);
        press = 1'b0;
    endtask : t_pin
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        {resetn, press, sw_mid_wr, sw_mid_data, pm_wr, pm_d, wm_wr, wr_wr, wr_d} = '0;
        wm_d = WDOG_MODE_WATCHDOG;
        full_src = '0;
        soft_src = '0;
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        chk({pin_mode, wdog_mode, wdog_run}, 3'h1);
        chk(resets, 3'h0);
        t_soft();
        t_wdog();
        t_mid();
        t_full();
        t_pin();
        give_verdict();
    end
endmodule : three_level_reset_generator_tb_top

// *** verilog/reset_gen_pkg.sv ***
// package: constants and carriers for the three level reset generator
package reset_gen_pkg;

    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam int unsigned SYS_CLK_HZ = 40000000;
    localparam int unsigned MIN_HOLD_CYCLES = 1;
    localparam int unsigned SYNC_STAGES = 3;

    // ----------------------------------------
    // watchdog and pin modes and reset values
    // ----------------------------------------
    typedef enum logic [0:0] {
        WDOG_MODE_WATCHDOG,
        WDOG_MODE_INTERVAL
    } wdog_mode_t;

    localparam logic PIN_MODE_RESET = 1'b0;
    localparam logic PIN_MODE_NMI = 1'b1;
    localparam logic PIN_MODE_RST_VAL = PIN_MODE_RESET;
    localparam wdog_mode_t WDOG_MODE_RST_VAL = WDOG_MODE_WATCHDOG;
    localparam logic WDOG_RUN_RST_VAL = 1'b1;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic deep_sleep_with_clock_wake;
        logic deep_sleep_full_off_wake;
        logic supervisor_low;
        logic supervisor_enable;
        logic sw_full_req;
    } full_src_t;

    typedef struct packed {
        logic wdog_expired;
        logic wdog_pw_violation;
        logic nvm_pw_violation;
        logic pmm_pw_violation;
        logic periph_fetch;
    } soft_src_t;

    typedef struct packed {
        logic full_device_reset;
        logic middle_reset;
        logic soft_clear_reset;
    } reset_levels_t;

endpackage : reset_gen_pkg

// *** verilog/three_level_reset_generator.sv ***
// module: three nested reset levels from pin, power, supervisor, watchdog and software sources
// Operation
// - full device reset only from power-up, reset pin, deep-sleep wake, supervisor, software.
// - full device reset always asserts middle reset; never the reverse.
// - middle reset from full device reset or software request only.
// - middle reset always asserts soft-clear reset; never the reverse.
// - soft-clear reset on watchdog, memory controller or power module password violation.
// - soft-clear on watchdog expiry only in watchdog mode.
// - soft-clear on instruction fetch from peripheral address region.
// - pulse bits store nothing; a written one makes one pulse; reads zero.
// - each register bit initialises on its designated reset level.
// - after full device reset the reset/NMI pin is in reset mode.
// - after full device reset the watchdog runs in watchdog mode.
`timescale 1ns/100ps
module three_level_reset_generator
    import reset_gen_pkg::*;
#(
    // synchroniser depth and minimum hold of each level
    parameter int unsigned SYNC_DEPTH = SYNC_STAGES,
    parameter int unsigned HOLD_CYCLES = MIN_HOLD_CYCLES
)
(
    // clock and power-up reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // external reset pin, asynchronous
    input wire logic RST_PIN_N,
    // full device reset sources
    input wire full_src_t FULL_SRC,
    // middle reset software pulse write
    input wire logic SW_MID_WR,
    input wire logic SW_MID_DATA,
    // soft-clear sources
    input wire soft_src_t SOFT_SRC,
    // configuration writes, pin mode reset by full device level, watchdog bits by soft-clear level
    input wire logic PIN_MODE_WR,
    input wire logic PIN_MODE_DATA,
    input wire logic WDOG_MODE_WR,
    input wire wdog_mode_t WDOG_MODE_DATA,
    input wire logic WDOG_RUN_WR,
    input wire logic WDOG_RUN_DATA,
    // reset levels
    output reset_levels_t RESETS,
    output logic SW_MID_PULSE,
    output logic SW_MID_RDATA,
    // configuration state
    output logic PIN_MODE,
    output wdog_mode_t WDOG_MODE,
    output logic WDOG_RUN
);

    // ----------------------------------------
    // reset pin synchroniser
    // ----------------------------------------
    // release of RESETN near an edge only keeps a level up one cycle longer,
    // so the reset input needs no synchroniser of its own
    logic [SYNC_DEPTH-1:0] pin_sync_reg;
    logic pin_stable;
    logic pin_low_reg;

    // the pin idles high, so the stages start high and no false press follows reset
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pin_sync_reg <= '1;
        end else begin
            pin_sync_reg <= {pin_sync_reg[SYNC_DEPTH-2:0], RST_PIN_N};
        end
    end

    // a change counts only once the second and third stages agree
    assign pin_stable = (pin_sync_reg[SYNC_DEPTH-2] == pin_sync_reg[SYNC_DEPTH-1]);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pin_low_reg <= 1'b0;
        end else if (pin_stable) begin
            pin_low_reg <= ~pin_sync_reg[SYNC_DEPTH-1];
        end
    end

    // ----------------------------------------
    // configuration state and reset levels
    // ----------------------------------------
    logic pin_mode_reg;
    wdog_mode_t wdog_mode_reg;
    logic wdog_run_reg;
    logic [2:0] lvl_req;
    logic [2:0] lvl_now;
    reset_levels_t levels;

    // ----------------------------------------
    // full device reset sources
    // ----------------------------------------
    logic full_req;
    logic pin_full_req;
    logic wake_full_req;
    logic supervisor_full_req;
    logic sw_full_req;

    // pin only resets while in reset mode; in nmi mode it is ignored here
    assign pin_full_req = pin_low_reg && (pin_mode_reg == PIN_MODE_RESET);
    assign wake_full_req = FULL_SRC.deep_sleep_with_clock_wake || FULL_SRC.deep_sleep_full_off_wake;
    assign supervisor_full_req = FULL_SRC.supervisor_low && FULL_SRC.supervisor_enable;
    assign sw_full_req = FULL_SRC.sw_full_req;
    assign full_req = pin_full_req || wake_full_req || supervisor_full_req || sw_full_req;

    // ----------------------------------------
    // middle reset pulse bit
    // ----------------------------------------
    logic mid_req;

    // no storage behind the bit, so a read can never return a stale one
    assign SW_MID_PULSE = SW_MID_WR && SW_MID_DATA;
    assign SW_MID_RDATA = 1'b0;
    assign mid_req = full_req || SW_MID_PULSE;

    // ----------------------------------------
    // soft-clear sources
    // ----------------------------------------
    logic soft_req;
    logic pw_soft_req;
    logic wdog_soft_req;
    logic fetch_soft_req;

    assign pw_soft_req = SOFT_SRC.wdog_pw_violation || SOFT_SRC.nvm_pw_violation
                       || SOFT_SRC.pmm_pw_violation;
    // expiry in interval mode is only a timer tick, never a reset
    assign wdog_soft_req = SOFT_SRC.wdog_expired && (wdog_mode_reg == WDOG_MODE_WATCHDOG);
    assign fetch_soft_req = SOFT_SRC.periph_fetch;
    assign soft_req = mid_req || pw_soft_req || wdog_soft_req || fetch_soft_req;

    // ----------------------------------------
    // reset level flops
    // ----------------------------------------
    // registered so each level lasts a full cycle and drops on a clock edge; the
    // hold count is equal for all levels, so the lower ones never drop first
    localparam int unsigned HOLD_W = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES) : 1;
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES - 1);

    // index 2 is the full level, 1 the middle, 0 soft-clear, as in the carrier
    assign lvl_req = {full_req, mid_req, soft_req};

    for (genvar lvl = 0; lvl < 3; lvl++) begin : g_level
        logic level_reg;
        logic [HOLD_W-1:0] hold_cnt_reg;

        always_ff @(posedge CLK_SYS or negedge RESETN) begin
            if (!RESETN) begin
                hold_cnt_reg <= '0;
            end else if (lvl_req[lvl]) begin
                hold_cnt_reg <= HOLD_LOAD;
            end else if (hold_cnt_reg != '0) begin
                hold_cnt_reg <= hold_cnt_reg - 1'b1;
            end
        end

        // raised at once, dropped only when the hold count has run out
        always_ff @(posedge CLK_SYS or negedge RESETN) begin
            if (!RESETN) begin
                level_reg <= 1'b1;
            end else begin
                level_reg <= lvl_req[lvl] || (hold_cnt_reg != '0);
            end
        end

        assign lvl_now[lvl] = level_reg;
    end

    assign levels = reset_levels_t'(lvl_now);
    assign RESETS = levels;

    // ----------------------------------------
    // configuration bits
    // ----------------------------------------
    logic pin_mode_wr_ok;
    logic wdog_mode_wr_ok;
    logic wdog_run_wr_ok;

    // a write in a cycle where the bit's own reset level stands is dropped
    assign pin_mode_wr_ok = PIN_MODE_WR && !levels.full_device_reset;
    assign wdog_mode_wr_ok = WDOG_MODE_WR && !levels.soft_clear_reset;
    assign wdog_run_wr_ok = WDOG_RUN_WR && !levels.soft_clear_reset;

    // pin mode initialises on the full device reset level
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pin_mode_reg <= PIN_MODE_RST_VAL;
        end else if (levels.full_device_reset) begin
            pin_mode_reg <= PIN_MODE_RST_VAL;
        end else if (pin_mode_wr_ok) begin
            pin_mode_reg <= PIN_MODE_DATA;
        end
    end

    // watchdog mode and run initialise on soft-clear, so any reset restarts it
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wdog_mode_reg <= WDOG_MODE_RST_VAL;
        end else if (levels.soft_clear_reset) begin
            wdog_mode_reg <= WDOG_MODE_RST_VAL;
        end else if (wdog_mode_wr_ok) begin
            wdog_mode_reg <= WDOG_MODE_DATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wdog_run_reg <= WDOG_RUN_RST_VAL;
        end else if (levels.soft_clear_reset) begin
            wdog_run_reg <= WDOG_RUN_RST_VAL;
        end else if (wdog_run_wr_ok) begin
            wdog_run_reg <= WDOG_RUN_DATA;
        end
    end

    // ----------------------------------------
    // configuration outputs
    // ----------------------------------------
    assign PIN_MODE = pin_mode_reg;
    assign WDOG_MODE = wdog_mode_reg;
    assign WDOG_RUN = wdog_run_reg;

endmodule : three_level_reset_generator
